//--- logic/ct_params.svh
/*
 * Constants of the pin continuity test block: timings, counts and reset values.
 * Assumes the core clock runs at 100 MHz and the includer sees no other ct_ macros.
 */
`ifndef CT_PARAMS_SVH
`define CT_PARAMS_SVH

`define CT_CLK_PERIOD_NS 10
`define CT_ENTRY_DELAY_NS 200
`define CT_SETTLE_NS 200
// Least time rounds up, longest time rounds down.
`define CT_ENTRY_CYCLES ((`CT_ENTRY_DELAY_NS + `CT_CLK_PERIOD_NS - 1) / `CT_CLK_PERIOD_NS)
`define CT_SETTLE_CYCLES (`CT_SETTLE_NS / `CT_CLK_PERIOD_NS)
`define CT_CNT_W 8
`define CT_SYNC_DEPTH 3
`define CT_TERM_COUNT 10
`define CT_DQ_W 16
`define CT_BYTE_W 8
`define CT_STRB_TRUE 8
`define CT_STRB_COMP 9
`define CT_LANE_RESET 1'b0
`define CT_WIDE_DEFAULT 1'b1

`endif

//--- logic/ct_pkg.sv
/*
 * Types shared by the pin continuity test block.
 * Assumes ct_params.svh is on the include path.
 */
package ct_pkg;
    // The whole test input pattern, sampled at pin level.
    typedef struct packed {
        logic [16:0] addr;
        logic [1:0] bank;
        logic [1:0] bank_group_sel;
        logic cke;
        logic activate_select_n;
        logic termination_ctl;
        logic ck_t;
        logic ck_c;
        logic cmd_parity_in;
        logic lower_mask_invert_n;
        logic upper_mask_invert_n;
        logic alert_n;
        logic reset_pin_n;
    } pattern_t;

    typedef enum logic [1:0] {ST_NORMAL, ST_ENTRY, ST_ACTIVE} mode_state_t;

    // Three-input parity used by every term.
    function automatic logic xor3(input logic a, input logic b, input logic c);
        xor3 = a ^ b ^ c;
    endfunction
endpackage

//--- logic/pin_continuity_test.sv
/*
 * Pin continuity test top: mode entry and exit, pin sampling, test output drive
 * and gating of the normal data path and of refresh.
 * Assumes pins arrive unsynchronised, the memory core drives the CORE_ ports on
 * CORE_CLK_I, and the pad ring resolves each lane from its data and enable.
 */
`include "ct_params.svh"

module pin_continuity_test
    import ct_pkg::*;
#(
    parameter bit WIDE = `CT_WIDE_DEFAULT
) (
    input wire logic CORE_CLK_I,
    input wire logic RESET_I,
    input wire logic TEST_MODE_PIN_I,
    input wire logic CS_N_I,
    input wire logic [16:0] ADDR_I,
    input wire logic [1:0] BANK_I,
    input wire logic [1:0] BANK_GROUP_SEL_I,
    input wire logic CKE_I,
    input wire logic ACTIVATE_SELECT_N_I,
    input wire logic TERMINATION_CTL_I,
    input wire logic CK_T_I,
    input wire logic CK_C_I,
    input wire logic CMD_PARITY_IN_I,
    input wire logic LOWER_MASK_INVERT_N_I,
    input wire logic UPPER_MASK_INVERT_N_I,
    input wire logic ALERT_N_I,
    input wire logic RESET_PIN_N_I,
    input wire logic [15:0] CORE_DQ_I,
    input wire logic CORE_DQ_OE_I,
    input wire logic [1:0] CORE_DQS_T_I,
    input wire logic [1:0] CORE_DQS_C_I,
    input wire logic CORE_DQS_OE_I,
    input wire logic CORE_REFRESH_REQ_I,
    input wire logic CORE_SELF_REFRESH_I,
    output logic [15:0] DQ_O,
    output logic [15:0] DQ_OE_O,
    output logic [1:0] DQS_T_O,
    output logic [1:0] DQS_C_O,
    output logic [1:0] DQS_OE_O,
    output logic REFRESH_GO_O,
    output logic SELF_REFRESH_GO_O,
    output logic CORE_BYPASS_O,
    output logic REINIT_NEEDED_O
);
    localparam int PAT_W = $bits(pattern_t);
    localparam int SYNC_W = PAT_W + 2;
    localparam int ENTRY_CYC = `CT_ENTRY_CYCLES;
    localparam int SETTLE_CYC = `CT_SETTLE_CYCLES;

    // The count widths and the output map only serve the two documented parts.
    // The entry compare looks two counts early, so fewer than two cycles cannot work.
    if (ENTRY_CYC < 2 || ENTRY_CYC >= (1 << `CT_CNT_W) || SETTLE_CYC < 6) begin : g_bad_timing
        $error("pin_continuity_test: timing counts out of range");
    end

    term_if tb ();
    xor_terms #(.WIDE(WIDE)) u_terms (.tb(tb.calc));

    // Raw pin bundle; the clock pins are only pattern data here, never clocks.
    logic [SYNC_W-1:0] raw_pins;
    pattern_t raw_pattern;
    always_comb begin
        raw_pattern.addr = ADDR_I;
        raw_pattern.bank = BANK_I;
        raw_pattern.bank_group_sel = BANK_GROUP_SEL_I;
        raw_pattern.cke = CKE_I;
        raw_pattern.activate_select_n = ACTIVATE_SELECT_N_I;
        raw_pattern.termination_ctl = TERMINATION_CTL_I;
        raw_pattern.ck_t = CK_T_I;
        raw_pattern.ck_c = CK_C_I;
        raw_pattern.cmd_parity_in = CMD_PARITY_IN_I;
        raw_pattern.lower_mask_invert_n = LOWER_MASK_INVERT_N_I;
        raw_pattern.upper_mask_invert_n = UPPER_MASK_INVERT_N_I;
        raw_pattern.alert_n = ALERT_N_I;
        raw_pattern.reset_pin_n = RESET_PIN_N_I;
        raw_pins = {TEST_MODE_PIN_I, CS_N_I, raw_pattern};
    end

    // Three-stage synchronisers; a bit is accepted once stages two and three agree.
    // All bits are sampled side by side, so the whole pattern moves in parallel.
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [SYNC_W-1:0] sync3;
    logic [SYNC_W-1:0] agreed;
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
            always_ff @(posedge CORE_CLK_I) begin
                if (RESET_I) begin
                    sync1[gi] <= `CT_LANE_RESET;
                    sync2[gi] <= `CT_LANE_RESET;
                    sync3[gi] <= `CT_LANE_RESET;
                    agreed[gi] <= `CT_LANE_RESET;
                end else begin
                    sync1[gi] <= raw_pins[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                    if (sync2[gi] == sync3[gi]) begin
                        agreed[gi] <= sync3[gi];
                    end
                end
            end
        end
    endgenerate

    logic test_pin;
    logic cs_n;
    assign test_pin = agreed[SYNC_W-1];
    assign cs_n = agreed[SYNC_W-2];
    assign tb.pattern = pattern_t'(agreed[PAT_W-1:0]);
    assign tb.test_pin = test_pin;

    // Mode sequencer: the pin must stay high for the entry delay before the
    // block takes over; a drop ends the mode at once.
    mode_state_t state;
    logic [`CT_CNT_W-1:0] entry_cnt;
    logic mode_active;
    assign mode_active = (state == ST_ACTIVE);

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            state <= ST_NORMAL;
        end else begin
            unique case (state)
                ST_NORMAL: begin
                    if (test_pin) begin
                        state <= ST_ENTRY;
                    end
                end
                ST_ENTRY: begin
                    if (!test_pin) begin
                        state <= ST_NORMAL;
                    end else if (entry_cnt == `CT_CNT_W'(ENTRY_CYC - 2)) begin
                        state <= ST_ACTIVE;
                    end
                end
                ST_ACTIVE: begin
                    if (!test_pin) begin
                        state <= ST_NORMAL;
                    end
                end
            endcase
        end
    end

    // Entry counter runs only while waiting to enter.
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I || state != ST_ENTRY) begin
            entry_cnt <= '0;
        end else begin
            entry_cnt <= entry_cnt + `CT_CNT_W'(1);
        end
    end

    // Leaving the mode leaves the array and state unknown; the flag stays until
    // the core reset, because only a full initialisation can clear it.
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            REINIT_NEEDED_O <= 1'b0;
        end else if (mode_active && !test_pin) begin
            REINIT_NEEDED_O <= 1'b1;
        end
    end

    // Next output values: test results while in the mode, all off during entry, core data otherwise.
    logic [15:0] next_dq;
    logic [15:0] next_dq_oe;
    logic [1:0] next_dqs_t;
    logic [1:0] next_dqs_c;
    logic [1:0] next_dqs_oe;
    logic test_drive;
    always_comb begin
        test_drive = !cs_n;
        if (mode_active) begin
            next_dq[`CT_BYTE_W-1:0] = tb.xor_term[`CT_BYTE_W-1:0];
            next_dqs_t[0] = tb.xor_term[`CT_STRB_TRUE];
            next_dqs_c[0] = tb.xor_term[`CT_STRB_COMP];
            if (WIDE) begin
                next_dq[`CT_DQ_W-1:`CT_BYTE_W] = ~tb.xor_term[`CT_BYTE_W-1:0];
                next_dqs_t[1] = ~tb.xor_term[`CT_STRB_TRUE];
                next_dqs_c[1] = ~tb.xor_term[`CT_STRB_COMP];
                next_dq_oe = {`CT_DQ_W{test_drive}};
                next_dqs_oe = {2{test_drive}};
            end else begin
                // The upper lane does not exist on the byte-wide part; keep it quiet.
                next_dq[`CT_DQ_W-1:`CT_BYTE_W] = '0;
                next_dqs_t[1] = 1'b0;
                next_dqs_c[1] = 1'b0;
                next_dq_oe = {{`CT_BYTE_W{1'b0}}, {`CT_BYTE_W{test_drive}}};
                next_dqs_oe = {1'b0, test_drive};
            end
        end else if (state == ST_ENTRY) begin
            // Normal drivers are off during entry so neither side fights the agent.
            next_dq = '0;
            next_dqs_t = '0;
            next_dqs_c = '0;
            next_dq_oe = '0;
            next_dqs_oe = '0;
        end else begin
            next_dq = CORE_DQ_I;
            next_dqs_t = CORE_DQS_T_I;
            next_dqs_c = CORE_DQS_C_I;
            next_dq_oe = {`CT_DQ_W{CORE_DQ_OE_I}};
            next_dqs_oe = {2{CORE_DQS_OE_I}};
        end
    end

    // Output flops: one register stage keeps pads free of decode glitches.
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            DQ_O <= '0;
            DQ_OE_O <= '0;
            DQS_T_O <= '0;
            DQS_C_O <= '0;
            DQS_OE_O <= '0;
        end else begin
            DQ_O <= next_dq;
            DQ_OE_O <= next_dq_oe;
            DQS_T_O <= next_dqs_t;
            DQS_C_O <= next_dqs_c;
            DQS_OE_O <= next_dqs_oe;
        end
    end

    // Core bypass and refresh gating start as soon as entry begins.
    always_comb begin
        CORE_BYPASS_O = (state != ST_NORMAL);
        REFRESH_GO_O = CORE_REFRESH_REQ_I && (state == ST_NORMAL);
        SELF_REFRESH_GO_O = CORE_SELF_REFRESH_I && (state == ST_NORMAL);
    end

    // Helper: cycles since any pin of the pattern, select or test mode pin last changed.
    logic [`CT_CNT_W-1:0] quiet_cnt;
    logic [SYNC_W-1:0] raw_last;
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            raw_last <= '0;
            quiet_cnt <= '0;
        end else begin
            raw_last <= raw_pins;
            if (raw_pins != raw_last) begin
                quiet_cnt <= '0;
            end else if (quiet_cnt != '1) begin
                quiet_cnt <= quiet_cnt + `CT_CNT_W'(1);
            end
        end
    end

    // Helper: cycles the synchronised test pin has been high.
    logic [`CT_CNT_W-1:0] pin_high_cnt;
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I || !test_pin) begin
            pin_high_cnt <= '0;
        end else if (pin_high_cnt != '1) begin
            pin_high_cnt <= pin_high_cnt + `CT_CNT_W'(1);
        end
    end

    localparam int SETTLE_LIM = SETTLE_CYC;

    mode_entry_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        $rose(mode_active) |-> pin_high_cnt == `CT_CNT_W'(ENTRY_CYC))
        else $error("mode entered at the wrong time");

    mode_follow_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (mode_active && !test_pin) |=> !mode_active && REINIT_NEEDED_O)
        else $error("mode did not end with the test pin");

    core_bypass_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (state != ST_NORMAL) |-> CORE_BYPASS_O && (mode_active || next_dq_oe == '0))
        else $error("core not bypassed in test mode");

    refresh_block_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (mode_active && (CORE_REFRESH_REQ_I || CORE_SELF_REFRESH_I))
        |-> !REFRESH_GO_O && !SELF_REFRESH_GO_O)
        else $error("refresh passed during test mode");

    select_float_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (mode_active && cs_n) [*2] |=> (DQ_OE_O == '0) && (DQS_OE_O == '0))
        else $error("outputs driven with select high");

    term_map_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (mode_active && WIDE) |=> DQ_O[15:8] == ~DQ_O[7:0]
        && DQ_O[7:0] == $past(tb.xor_term[7:0]) && DQS_T_O == {~DQS_T_O[0], DQS_T_O[0]})
        else $error("test output map wrong");

    settle_time_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (mode_active && quiet_cnt == `CT_CNT_W'(SETTLE_LIM) && $stable(mode_active))
        |-> DQ_O[7:0] == tb.xor_term[7:0] && DQS_C_O[0] == tb.xor_term[9])
        else $error("outputs not settled in time");

    normal_path_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        (state == ST_NORMAL && !test_pin) |=> DQ_O == $past(CORE_DQ_I))
        else $error("normal data path disturbed");

    entry_cover: cover property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        $rose(mode_active));
    drive_cover: cover property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        mode_active && DQ_OE_O[0] ##1 !mode_active);
    abort_cover: cover property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        state == ST_ENTRY ##1 state == ST_NORMAL);
endmodule

//--- logic/term_if.sv
/*
 * Carrier between the test top and its term generator.
 * Assumes both ends share one clock domain; the signals are combinational.
 */
interface term_if;
    import ct_pkg::*;
    pattern_t pattern;
    logic test_pin;
    logic [9:0] xor_term;
    modport calc (input pattern, input test_pin, output xor_term);
    modport use_terms (output pattern, output test_pin, input xor_term);
endinterface

//--- logic/xor_terms.sv
/*
 * Term generator: forms the ten parity terms from a settled test pattern.
 * Assumes its pattern comes from synchronised, agreed pin samples.
 */
module xor_terms
    import ct_pkg::*;
#(
    parameter bit WIDE = 1'b1
) (
    term_if.calc tb
);
    // Each term is a three-way parity of pattern bits; term 9 gates its reset pin bit with the test pin.
    always_comb begin
        tb.xor_term[0] = xor3(tb.pattern.addr[1], tb.pattern.addr[6],
                              tb.pattern.cmd_parity_in);
        tb.xor_term[1] = xor3(tb.pattern.addr[8], tb.pattern.alert_n,
                              tb.pattern.addr[9]);
        tb.xor_term[2] = xor3(tb.pattern.addr[2], tb.pattern.addr[5],
                              tb.pattern.addr[13]);
        tb.xor_term[3] = xor3(tb.pattern.addr[0], tb.pattern.addr[7],
                              tb.pattern.addr[11]);
        tb.xor_term[4] = xor3(tb.pattern.ck_c, tb.pattern.termination_ctl,
                              tb.pattern.addr[15]);
        tb.xor_term[5] = xor3(tb.pattern.cke, tb.pattern.addr[16],
                              tb.pattern.addr[10]);
        tb.xor_term[6] = xor3(tb.pattern.activate_select_n, tb.pattern.addr[4],
                              tb.pattern.bank[1]);
        // The byte-wide part has no upper mask, so a bank group bit takes its place.
        if (WIDE) begin
            tb.xor_term[7] = xor3(tb.pattern.upper_mask_invert_n,
                                  tb.pattern.lower_mask_invert_n, tb.pattern.ck_t);
        end else begin
            tb.xor_term[7] = xor3(tb.pattern.bank_group_sel[1],
                                  tb.pattern.lower_mask_invert_n, tb.pattern.ck_t);
        end
        tb.xor_term[8] = xor3(tb.pattern.addr[14], tb.pattern.addr[12],
                              tb.pattern.bank[0]);
        tb.xor_term[9] = xor3(tb.pattern.bank_group_sel[0], tb.pattern.addr[3],
                              tb.pattern.reset_pin_n & tb.test_pin);
    end
endmodule

//--- sim/ct_agent.sv
/*
 * Test agent model: drives the test mode, select and pattern pins and resolves
 * the data and strobe wires that the block drives. Assumes the bench calls its
 * tasks and that no other party drives the data wires in test mode.
 */
module ct_agent
    import ct_pkg::*;
(
    input wire logic clk_i,
    input wire logic [15:0] dq_i,
    input wire logic [15:0] dq_oe_i,
    input wire logic [1:0] dqs_t_i,
    input wire logic [1:0] dqs_c_i,
    input wire logic [1:0] dqs_oe_i,
    output logic test_pin_o,
    output logic cs_n_o,
    output pattern_t pattern_o,
    output logic [19:0] wire_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [19:0] held = '0;
    logic [19:0] oe;

    // A released lane shows the inverse of the level last driven on it, so a float
    // never reads as data.
    assign oe = {dqs_oe_i, dqs_oe_i, dq_oe_i};
    assign wire_o = (oe & {dqs_c_i, dqs_t_i, dq_i}) | (~oe & ~held);

    // The level last driven on each lane is kept; a floating lane keeps its old value.
    always_ff @(posedge clk_i) begin
        held <= (oe & {dqs_c_i, dqs_t_i, dq_i}) | (~oe & held);
    end

    // Pins start in normal operation with the reset pin high.
    initial begin
        test_pin_o = 1'b0;
        cs_n_o = 1'b1;
        pattern_o = '0;
        pattern_o.reset_pin_n = 1'b1;
    end

    // Pins change only at the falling edge, clear of the sampling edge.
    task automatic apply(input pattern_t p);
        @(negedge clk_i);
        pattern_o = p;
        pattern_o.reset_pin_n = 1'b1;
    endtask

    // Entry is only called once power-on reset is over and before any calibration.
    task automatic enter();
        @(negedge clk_i);
        test_pin_o = 1'b1;
    endtask

    // Leaving is allowed at any time; the caller then resets the device.
    task automatic leave();
        @(negedge clk_i);
        test_pin_o = 1'b0;
    endtask

    task automatic select(input logic cs_n);
        @(negedge clk_i);
        cs_n_o = cs_n;
    endtask
endmodule

//--- sim/pin_continuity_test_tb.sv
/*
 * Self-checking bench of the pin continuity test block, wide and byte-wide variants.
 * Assumes the test agent model drives the pins and resolves the test outputs.
 */
module pin_continuity_test_tb
    import ct_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] core_dq = 16'ha5c3;
    logic core_dq_oe = 1'b1;
    logic [1:0] core_dqs_t = 2'h1;
    logic [1:0] core_dqs_c = 2'h2;
    logic core_dqs_oe = 1'b1;
    logic ref_req = 1'b1;
    logic sref_req = 1'b1;
    logic [15:0] dq, dq_oe;
    logic [1:0] dqs_t, dqs_c, dqs_oe;
    logic ref_go, sref_go, bypass, reinit, test_mode_pin, cs_n;
    logic [19:0] wires;
    logic [15:0] dq8, dq_oe8;
    logic [1:0] dqs_t8, dqs_c8, dqs_oe8;
    pattern_t pat;
    int fail_count = 0;
    int comparisons = 0;

    pin_continuity_test #(.WIDE(1'b1)) DUT (.CORE_CLK_I(clk), .RESET_I(rst),
        .TEST_MODE_PIN_I(test_mode_pin), .CS_N_I(cs_n), .ADDR_I(pat.addr), .BANK_I(pat.bank),
        .BANK_GROUP_SEL_I(pat.bank_group_sel), .CKE_I(pat.cke),
        .ACTIVATE_SELECT_N_I(pat.activate_select_n), .TERMINATION_CTL_I(pat.termination_ctl),
        .CK_T_I(pat.ck_t), .CK_C_I(pat.ck_c), .CMD_PARITY_IN_I(pat.cmd_parity_in),
        .LOWER_MASK_INVERT_N_I(pat.lower_mask_invert_n),
        .UPPER_MASK_INVERT_N_I(pat.upper_mask_invert_n), .ALERT_N_I(pat.alert_n),
        .RESET_PIN_N_I(pat.reset_pin_n), .CORE_DQ_I(core_dq), .CORE_DQ_OE_I(core_dq_oe),
        .CORE_DQS_T_I(core_dqs_t), .CORE_DQS_C_I(core_dqs_c), .CORE_DQS_OE_I(core_dqs_oe),
        .CORE_REFRESH_REQ_I(ref_req), .CORE_SELF_REFRESH_I(sref_req), .DQ_O(dq),
        .DQ_OE_O(dq_oe), .DQS_T_O(dqs_t), .DQS_C_O(dqs_c), .DQS_OE_O(dqs_oe),
        .REFRESH_GO_O(ref_go), .SELF_REFRESH_GO_O(sref_go), .CORE_BYPASS_O(bypass),
        .REINIT_NEEDED_O(reinit));

    // Byte-wide variant on the same pins; only its test outputs are judged.
    pin_continuity_test #(.WIDE(1'b0)) DUT_BYTE (.CORE_CLK_I(clk), .RESET_I(rst),
        .TEST_MODE_PIN_I(test_mode_pin), .CS_N_I(cs_n), .ADDR_I(pat.addr), .BANK_I(pat.bank),
        .BANK_GROUP_SEL_I(pat.bank_group_sel), .CKE_I(pat.cke),
        .ACTIVATE_SELECT_N_I(pat.activate_select_n), .TERMINATION_CTL_I(pat.termination_ctl),
        .CK_T_I(pat.ck_t), .CK_C_I(pat.ck_c), .CMD_PARITY_IN_I(pat.cmd_parity_in),
        .LOWER_MASK_INVERT_N_I(pat.lower_mask_invert_n),
        .UPPER_MASK_INVERT_N_I(pat.upper_mask_invert_n), .ALERT_N_I(pat.alert_n),
        .RESET_PIN_N_I(pat.reset_pin_n), .CORE_DQ_I(core_dq), .CORE_DQ_OE_I(core_dq_oe),
        .CORE_DQS_T_I(core_dqs_t), .CORE_DQS_C_I(core_dqs_c), .CORE_DQS_OE_I(core_dqs_oe),
        .CORE_REFRESH_REQ_I(ref_req), .CORE_SELF_REFRESH_I(sref_req), .DQ_O(dq8),
        .DQ_OE_O(dq_oe8), .DQS_T_O(dqs_t8), .DQS_C_O(dqs_c8), .DQS_OE_O(dqs_oe8),
        .REFRESH_GO_O(), .SELF_REFRESH_GO_O(), .CORE_BYPASS_O(), .REINIT_NEEDED_O());

    ct_agent agent (.clk_i(clk), .dq_i(dq), .dq_oe_i(dq_oe), .dqs_t_i(dqs_t),
        .dqs_c_i(dqs_c), .dqs_oe_i(dqs_oe), .test_pin_o(test_mode_pin), .cs_n_o(cs_n),
        .pattern_o(pat), .wire_o(wires));

    // Free-running core clock of 100 MHz.
    initial begin
        forever #5 clk = ~clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Expected wire levels, strobes above data, worked out from the pin levels.
    function automatic logic [19:0] expect_wires(input pattern_t p, input logic tp,
                                                 input logic wide);
        logic [9:0] t;
        t[0] = p.addr[1] ^ p.addr[6] ^ p.cmd_parity_in;
        t[1] = p.addr[8] ^ p.alert_n ^ p.addr[9];
        t[2] = p.addr[2] ^ p.addr[5] ^ p.addr[13];
        t[3] = p.addr[0] ^ p.addr[7] ^ p.addr[11];
        t[4] = p.ck_c ^ p.termination_ctl ^ p.addr[15];
        t[5] = p.cke ^ p.addr[16] ^ p.addr[10];
        t[6] = p.activate_select_n ^ p.addr[4] ^ p.bank[1];
        t[7] = wide ? (p.upper_mask_invert_n ^ p.lower_mask_invert_n ^ p.ck_t)
                    : (p.bank_group_sel[1] ^ p.lower_mask_invert_n ^ p.ck_t);
        t[8] = p.addr[14] ^ p.addr[12] ^ p.bank[0];
        t[9] = p.bank_group_sel[0] ^ p.addr[3] ^ (p.reset_pin_n & tp);
        return {~t[9], t[9], ~t[8], t[8], ~t[7:0], t[7:0]};
    endfunction

    task automatic do_reset();
        @(negedge clk);
        rst = 1'b1;
        cyc(6);
        rst = 1'b0;
    endtask

    // Out of reset the core path is passed through and refresh is let through.
    task automatic t_normal();
        cyc(3);
        check("core path", wires, {core_dqs_c, core_dqs_t, core_dq});
        check("core oe", {4'h0, dq_oe}, 20'h0ffff);
        check("refresh pass", {ref_go, sref_go, bypass, reinit}, 4'hc);
    endtask

    // Entry holds the drivers off before 200 ns and bypasses the core at once.
    task automatic t_entry();
        int n;
        agent.select(1'b0);
        agent.enter();
        cyc(6);
        check("bypass", bypass, 1'b1);
        check("refresh gated", {ref_go, sref_go}, 2'h0);
        cyc(13);
        check("early drive", {dq_oe, dqs_oe}, 18'h0);
        n = 0;
        while (dq_oe !== 16'hffff && n < 40) begin
            cyc(1);
            n++;
        end
        check("entered", {dq_oe, dqs_oe}, 18'h3ffff);
    endtask

    // Walking one over every pattern pin but reset, plus all pins high.
    task automatic t_terms();
        pattern_t p;
        logic [30:0] v;
        logic [19:0] e8;
        core_dq = ~core_dq;
        for (int i = 0; i < 32; i++) begin
            v = (i == 0) ? 31'h0 : 31'h1 << i;
            p = (i == 31) ? '1 : 31'h1 ^ v;
            agent.apply(p);
            cyc(20);
            check("terms", wires, expect_wires(p, 1'b1, 1'b1));
            // The byte-wide part drives only the low lane; upper data and strobes stay low.
            e8 = expect_wires(p, 1'b1, 1'b0) & 20'h500ff;
            check("terms x8", {dqs_c8, dqs_t8, dq8}, e8);
        end
        check("core blocked", {ref_go, sref_go}, 2'h0);
        check("x8 drive", {dq_oe8, dqs_oe8}, 18'h003fd);
    endtask

    // A high select floats every test output; low drives them again.
    task automatic t_select();
        agent.select(1'b1);
        cyc(20);
        check("float", {dq_oe, dqs_oe}, 18'h0);
        check("float level", wires, ~expect_wires(pat, 1'b1, 1'b1));
        agent.select(1'b0);
        cyc(20);
        check("drive", {dq_oe, dqs_oe}, 18'h3ffff);
    endtask

    // Leaving the mode flags a reinitialisation and gives the pins back.
    task automatic t_exit();
        agent.leave();
        cyc(8);
        check("exit", {ref_go, sref_go, bypass, reinit}, 4'hd);
        check("core back", wires, {core_dqs_c, core_dqs_t, core_dq});
        do_reset();
        cyc(2);
        check("reinit clear", reinit, 1'b0);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // The whole run takes under 2000 cycles; the limit leaves ample margin.
    initial begin
        #100us;
        fail_count++;
        report_and_stop();
    end

    initial begin
        cyc(6);
        rst = 1'b0;
        t_normal();
        t_entry();
        t_terms();
        t_select();
        t_exit();
        report_and_stop();
    end
endmodule
